// [logic/dbs_pkg.sv]
// shared constants for the dynamic bus sizing write path
// assumes a single clock domain and no software-visible registers
package dbs_pkg;
  // size codes, bytes remaining
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  // port width acknowledge codes {hi, lo}
  localparam logic [1:0] ACK_PORT8  = 2'h1;
  localparam logic [1:0] ACK_PORT16 = 2'h2;
  localparam logic [1:0] ACK_PORT32 = 2'h3;
  localparam logic [1:0] ACK_NONE   = 2'h0;
  // request fifo shape: 32 data + 30 base + 2 offset + 2 size + 1 fetch + 1 write
  localparam int FIFO_WIDTH = 68;
  localparam int FIFO_DEPTH = 16;
endpackage

// [logic/req_fifo.sv]
// synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable
`timescale 1ns/1ns
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  // honest flags from the occupancy count
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // pointer and count next values
  always_comb
  begin
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register state; storage has no reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      if (push)
        mem[wr_reg] <= in_data;
    end
  end
endmodule // req_fifo

// [logic/bus_sizer.sv]
// operand access sequencer and write data multiplexer for a sized bus
// assumes the slave answers each cycle with its port width acknowledge
`timescale 1ns/1ns
module bus_sizer (
  // clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  // operand request
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [31:0] REQ_ADDR,
  input  wire logic [1:0]  REQ_SIZE,
  input  wire logic [31:0] REQ_DATA,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_FETCH,
  // external bus cycle
  output logic             CYC_ACTIVE,
  output logic             CYC_WRITE,
  output logic [29:0]      LONG_BASE,
  output logic             XFER_SIZE_HI,
  output logic             XFER_SIZE_LO,
  output logic             BYTE_OFFSET_HI,
  output logic             BYTE_OFFSET_LO,
  output logic [31:0]      DATA_OUT,
  input  wire logic        PORT_WIDTH_ACK_HI,
  input  wire logic        PORT_WIDTH_ACK_LO,
  // completion
  output logic             OP_DONE,
  output logic             ADDR_ERROR
);
  typedef enum logic [0:0] {ST_IDLE, ST_CYCLE} state_t;

  localparam int W = dbs_pkg::FIFO_WIDTH;

  state_t      state_reg;
  state_t      state_next;
  logic [29:0] base_reg;
  logic [29:0] base_next;
  logic [1:0]  offs_reg;
  logic [1:0]  offs_next;
  logic [2:0]  rem_reg;
  logic [2:0]  rem_next;
  logic [31:0] opnd_reg;
  logic [31:0] opnd_next;
  logic        wr_reg;
  logic        wr_next;
  logic        done_reg;
  logic        done_next;
  logic        aerr_reg;
  logic        aerr_next;
  logic [31:0] lanes_reg;
  logic [31:0] lanes_next;
  logic [W-1:0] fifo_in;
  logic [W-1:0] fifo_out;
  logic         f_valid;
  logic         f_ready;
  logic [1:0]   ack;
  logic [1:0]   size_code;
  logic [2:0]   moved;
  logic [2:0]   room;
  logic [2:0]   f_bytes;
  logic [7:0]   b0, b1, b2, b3;

  // requests queue ahead of the sequencer so the core is not stalled per cycle
  assign fifo_in = {REQ_DATA, REQ_ADDR, REQ_FETCH, REQ_WRITE, REQ_SIZE};

  req_fifo #(.WIDTH(W), .DEPTH(dbs_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (REF_CLK),
    .rst       (SYS_RST),
    .ce        (CLK_EN),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   (fifo_in),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (fifo_out)
  );

  assign ack = {PORT_WIDTH_ACK_HI, PORT_WIDTH_ACK_LO};
  // remaining count 4 wraps to code 00 for a long word
  assign size_code = rem_reg[1:0];
  assign f_bytes = (fifo_out[1:0] == dbs_pkg::SIZE_LONG) ? 3'h4 : {1'b0, fifo_out[1:0]};
  assign f_ready = (state_reg == ST_IDLE);

  // bytes the acked port can take from this offset
  always_comb
  begin
    case (ack)
      dbs_pkg::ACK_PORT32: room = 3'h4 - {1'b0, offs_reg};
      dbs_pkg::ACK_PORT16: room = offs_reg[0] ? 3'h1 : 3'h2;
      dbs_pkg::ACK_PORT8:  room = 3'h1;
      default:             room = 3'h0;
    endcase
    moved = (room < rem_reg) ? room : rem_reg;
  end

  // operand bytes, numbered from the most significant down
  assign b0 = opnd_reg[31:24];
  assign b1 = opnd_reg[23:16];
  assign b2 = opnd_reg[15:8];
  assign b3 = opnd_reg[7:0];

  // write multiplexer; unused x lanes repeat a byte already present, except 7:0 of three at offset 0 and 15:8 of sizes above byte at offset 3
  always_comb
  begin
    case ({size_code, offs_reg})
      4'h4, 4'h5, 4'h6, 4'h7: lanes_next = {b3, b3, b3, b3};
      4'h8, 4'hA:             lanes_next = {b2, b3, b2, b3};
      4'h9, 4'hB:             lanes_next = {b2, b2, b3, b2};
      4'hC:                   lanes_next = {b1, b2, b3, b0};
      4'hD:                   lanes_next = {b1, b1, b2, b3};
      4'hE:                   lanes_next = {b1, b2, b1, b2};
      4'hF:                   lanes_next = {b1, b1, b2, b1};
      4'h0:                   lanes_next = {b0, b1, b2, b3};
      4'h1:                   lanes_next = {b0, b0, b1, b2};
      4'h2:                   lanes_next = {b0, b1, b0, b1};
      4'h3:                   lanes_next = {b0, b0, b1, b0};
      default:                lanes_next = {b0, b1, b2, b3};
    endcase
  end

  // sequencer next state
  always_comb
  begin
    state_next = state_reg;
    base_next  = base_reg;
    offs_next  = offs_reg;
    rem_next   = rem_reg;
    opnd_next  = opnd_reg;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    aerr_next  = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (f_valid)
        begin
          // odd prefetch faults; data is accepted at any byte address
          if (fifo_out[3] && fifo_out[4])
          begin
            aerr_next = 1'b1;
          end
          else
          begin
            state_next = ST_CYCLE;
            base_next  = fifo_out[35:6];
            offs_next  = fifo_out[5:4];
            rem_next   = f_bytes;
            opnd_next  = fifo_out[67:36];
            wr_next    = fifo_out[2];
          end
        end
      end
      ST_CYCLE:
      begin
        if (moved != 3'h0)
        begin
          // advance past the bytes moved, carrying into the long-word base
          rem_next = rem_reg - moved;
          {base_next, offs_next} = {base_reg, offs_reg} + {27'h0, moved};
          if (rem_reg == moved)
          begin
            state_next = ST_IDLE;
            done_next  = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      state_reg <= ST_IDLE;
      base_reg  <= '0;
      offs_reg  <= '0;
      rem_reg   <= '0;
      opnd_reg  <= '0;
      wr_reg    <= 1'b0;
      done_reg  <= 1'b0;
      aerr_reg  <= 1'b0;
      lanes_reg <= '0;
    end
    else if (CLK_EN)
    begin
      state_reg <= state_next;
      base_reg  <= base_next;
      offs_reg  <= offs_next;
      rem_reg   <= rem_next;
      opnd_reg  <= opnd_next;
      wr_reg    <= wr_next;
      done_reg  <= done_next;
      aerr_reg  <= aerr_next;
      lanes_reg <= lanes_next;
    end
  end

  // data lanes are driven combinationally from current code so they match it
  assign DATA_OUT       = lanes_next;
  assign CYC_ACTIVE     = (state_reg == ST_CYCLE);
  assign CYC_WRITE      = wr_reg;
  assign LONG_BASE      = base_reg;
  assign XFER_SIZE_HI   = size_code[1];
  assign XFER_SIZE_LO   = size_code[0];
  assign BYTE_OFFSET_HI = offs_reg[1];
  assign BYTE_OFFSET_LO = offs_reg[0];
  assign OP_DONE        = done_reg;
  assign ADDR_ERROR     = aerr_reg;

  // assertions
  a_byte_lanes_copy: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_BYTE |-> DATA_OUT == {4{opnd_reg[7:0]}})
    else $error("byte write not copied to all lanes");
  a_word_even_lanes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_WORD && !offs_reg[0]
      |-> DATA_OUT == {opnd_reg[15:0], opnd_reg[15:0]})
    else $error("word even lanes wrong");
  a_long_aligned_lanes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_LONG && offs_reg == 2'h0 |-> DATA_OUT == opnd_reg)
    else $error("aligned long lanes wrong");
  a_three_off1_lanes: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_THREE && offs_reg == 2'h1
      |-> DATA_OUT[23:0] == opnd_reg[23:0])
    else $error("three byte offset one lanes wrong");
  a_long_word16_follow: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_LONG && offs_reg == 2'h0 && ack == dbs_pkg::ACK_PORT16
      |=> CYC_ACTIVE && size_code == dbs_pkg::SIZE_WORD && offs_reg == 2'h2
          && DATA_OUT[31:16] == opnd_reg[15:0])
    else $error("long to 16-bit port follow-on wrong");
  a_odd_long_word16: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_LONG && offs_reg == 2'h1 && ack == dbs_pkg::ACK_PORT16
      |=> size_code == dbs_pkg::SIZE_THREE && offs_reg == 2'h2)
    else $error("odd long to 16-bit port second cycle wrong");
  a_word_byte_port: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_WORD && ack == dbs_pkg::ACK_PORT8
      |=> CYC_ACTIVE && size_code == dbs_pkg::SIZE_BYTE && !OP_DONE)
    else $error("word to byte port not split");
  a_off3_long32_done: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
    CYC_ACTIVE && size_code == dbs_pkg::SIZE_LONG && offs_reg == 2'h3 && ack == dbs_pkg::ACK_PORT32
      |=> size_code == dbs_pkg::SIZE_THREE && offs_reg == 2'h0
          ##1 (ack != dbs_pkg::ACK_PORT32) || OP_DONE || !CLK_EN)
    else $error("offset three long not two cycles");
  a_odd_fetch_error: assert property (@(posedge REF_CLK) disable iff (SYS_RST || !CLK_EN)
    state_reg == ST_IDLE && f_valid && fifo_out[3] && fifo_out[4] |=> ADDR_ERROR && !CYC_ACTIVE)
    else $error("odd prefetch did not fault");
endmodule // bus_sizer

// [verification/slave_port.sv]
// behavioural model of a memory or peripheral port on the sized bus
// assumes one clock; width code and wait count change only while idle
`timescale 1ns/1ns
module slave_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // bus cycle from the sizer
  input  wire logic        cyc_active,
  input  wire logic [31:0] data_in,
  // port shape set by the bench
  input  wire logic [1:0]  width_code,
  input  wire logic [3:0]  waits,
  // acknowledge back to the sizer
  output logic             ack_hi,
  output logic             ack_lo
);
  logic [3:0]  cnt_reg;
  logic [31:0] latch_reg;
  // ack shows the port width once the wait states have run out
  assign {ack_hi, ack_lo} = (cyc_active && cnt_reg >= waits) ? width_code : 2'h0;
  // only the port's own upper lanes are latched; x lanes outside the port width never reach its store
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_reg <= 4'h0;
    else if (ack_hi || ack_lo)
    begin
      cnt_reg   <= 4'h0;
      latch_reg <= data_in & {8'hFF, {8{ack_hi}}, {16{ack_hi & ack_lo}}};
    end
    else if (cyc_active)
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // slave_port

// [verification/dynamic_bus_sizing_write_mux_tb.sv]
// self-checking bench for the bus sizer with a port model
// assumes bus_sizer, req_fifo and dbs_pkg are compiled first
`timescale 1ns/1ns
module dynamic_bus_sizing_write_mux_tb;
  typedef struct {logic [31:0] a; logic [1:0] s; logic [31:0] d; logic w; logic f;} op_t;
  logic REF_CLK, SYS_RST, CLK_EN, REQ_VALID, REQ_READY, REQ_WRITE, REQ_FETCH;
  logic [31:0] REQ_ADDR, REQ_DATA, DATA_OUT;
  logic [1:0]  REQ_SIZE, pw;
  logic [3:0]  waits;
  logic        CYC_ACTIVE, CYC_WRITE, OP_DONE, ADDR_ERROR, ack_hi, ack_lo;
  logic        XFER_SIZE_HI, XFER_SIZE_LO, BYTE_OFFSET_HI, BYTE_OFFSET_LO;
  logic [29:0] LONG_BASE, base;
  logic [1:0]  o;
  logic        busy, done_exp, en_prev, fin, saw_full, rnd_en;
  int          error_cnt, n_compared, r, cyc_cnt, m;
  op_t         q[$];
  op_t         cur;
  bus_sizer dut_u (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_ADDR(REQ_ADDR), .REQ_SIZE(REQ_SIZE),
    .REQ_DATA(REQ_DATA), .REQ_WRITE(REQ_WRITE), .REQ_FETCH(REQ_FETCH),
    .CYC_ACTIVE(CYC_ACTIVE), .CYC_WRITE(CYC_WRITE), .LONG_BASE(LONG_BASE),
    .XFER_SIZE_HI(XFER_SIZE_HI), .XFER_SIZE_LO(XFER_SIZE_LO), .BYTE_OFFSET_HI(BYTE_OFFSET_HI),
    .BYTE_OFFSET_LO(BYTE_OFFSET_LO), .DATA_OUT(DATA_OUT), .PORT_WIDTH_ACK_HI(ack_hi),
    .PORT_WIDTH_ACK_LO(ack_lo), .OP_DONE(OP_DONE), .ADDR_ERROR(ADDR_ERROR));
  slave_port port_u (.clk(REF_CLK), .rst(SYS_RST), .cyc_active(CYC_ACTIVE), .data_in(DATA_OUT),
    .width_code(pw), .waits(waits), .ack_hi(ack_hi), .ack_lo(ack_lo));
  // ********************************
  // expectation functions
  // ********************************
  // lane pattern from bytes remaining and offset, top lane first
  function automatic logic [31:0] lanes(int n, logic [1:0] off, logic [31:0] d);
    logic [7:0] b0, b1, b2, b3;
    {b0, b1, b2, b3} = d;
    case (n)
      1: return {4{b3}};
      2: return off[0] ? {b2, b2, b3, b2} : {b2, b3, b2, b3};
      3: case (off)
           2'h0: return {b1, b2, b3, b0};
           2'h1: return {b1, b1, b2, b3};
           2'h2: return {b1, b2, b1, b2};
           default: return {b1, b1, b0, b1};
         endcase
      default: case (off)
           2'h0: return {b0, b1, b2, b3};
           2'h1: return {b0, b0, b1, b2};
           2'h2: return {b0, b1, b0, b1};
           default: return {b0, b0, b1, b0};
         endcase
    endcase
  endfunction
  // lanes no port uses are left out of the compare only for three bytes at offset 0 and three or four bytes at offset 3
  function automatic logic [31:0] lmask(int n, logic [1:0] off);
    if (n == 3 && off == 2'h0) return 32'hFFFFFF00;
    if (n >= 3 && off == 2'h3) return 32'hFFFF00FF;
    return 32'hFFFFFFFF;
  endfunction
  // bytes one cycle moves: the smaller of remaining and port room
  function automatic int moved(int n, logic [1:0] off, logic [1:0] w);
    int room;
    room = (w == dbs_pkg::ACK_PORT32) ? 4 - off : (w == dbs_pkg::ACK_PORT16) ? 2 - off[0] : 1;
    return (n < room) ? n : room;
  endfunction
  // ********************************
  // checking and closing
  // ********************************
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // clock, hang guard and random enable gaps
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK)
  begin
    cyc_cnt++;
    CLK_EN <= rnd_en ? ($urandom % 8 != 0) : 1'b1;
    if (cyc_cnt == 60000)
    begin
      error_cnt++;
      test_done();
    end
  end
  // ********************************
  // bus monitor
  // ********************************
  // inputs move only on rising edges, so the falling edge sees settled values
  always @(negedge REF_CLK)
  begin
    fin = 1'b0;
    if (!SYS_RST)
    begin
      chk(OP_DONE, done_exp);
      if (ADDR_ERROR && en_prev)
      begin
        chk(q.size() > 0 && q[0].f && q[0].a[0], 1);
        void'(q.pop_front());
      end
      if (CYC_ACTIVE && (ack_hi || ack_lo) && CLK_EN)
      begin
        if (!busy)
        begin
          cur = q.pop_front();
          r = (cur.s == 2'h0) ? 4 : cur.s;
          {base, o} = cur.a;
          busy = 1'b1;
          chk(cur.f && cur.a[0], 0);
        end
        chk({XFER_SIZE_HI, XFER_SIZE_LO}, r[1:0]);
        chk({BYTE_OFFSET_HI, BYTE_OFFSET_LO}, o);
        chk(LONG_BASE, base);
        chk(CYC_WRITE, cur.w);
        chk(DATA_OUT & lmask(r, o), lanes(r, o, cur.d) & lmask(r, o));
        // bytes moved are taken from the offset before it advances
        m = moved(r, o, {ack_hi, ack_lo});
        {base, o} = {base, o} + 32'(m);
        r = r - m;
        fin = (r == 0);
        busy = !fin;
      end
      if (CLK_EN)
        done_exp = fin;
    end
    en_prev = CLK_EN;
  end
  // ********************************
  // drivers and scenarios
  // ********************************
  task automatic send(logic [31:0] a, logic [1:0] s, logic w, logic f);
    logic [31:0] d;
    d = $urandom;
    REQ_VALID <= 1'b1;
    REQ_ADDR <= a;
    REQ_SIZE <= s;
    REQ_DATA <= d;
    REQ_WRITE <= w;
    REQ_FETCH <= f;
    forever
    begin
      @(negedge REF_CLK);
      if (!REQ_READY) saw_full = 1'b1;
      if (REQ_READY && CLK_EN) break;
    end
    @(posedge REF_CLK);
    q.push_back('{a, s, d, w, f});
  endtask
  // release the request, then wait for all queued work to finish
  task automatic drain();
    REQ_VALID <= 1'b0;
    for (int i = 0; i < 3000 && (q.size() > 0 || busy); i++) @(posedge REF_CLK);
    repeat (3) @(posedge REF_CLK);
  endtask
  task automatic one(logic [1:0] p, logic [31:0] a, logic [1:0] s, logic f);
    pw <= p;
    @(posedge REF_CLK);
    send(a, s, 1'b1, f);
    drain();
  endtask
  initial
  begin
    REF_CLK = 0; SYS_RST = 1; CLK_EN = 1; REQ_VALID = 0; REQ_ADDR = 0; REQ_SIZE = 0;
    REQ_DATA = 0; REQ_WRITE = 0; REQ_FETCH = 0; pw = 2'h3; waits = 0; busy = 0;
    done_exp = 0; en_prev = 1; saw_full = 0; rnd_en = 0; error_cnt = 0; n_compared = 0;
    void'($urandom(25079));
    repeat (5) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(negedge REF_CLK);
    chk(REQ_READY, 1);
    chk(CYC_ACTIVE, 0);
    @(posedge REF_CLK);
    one(dbs_pkg::ACK_PORT16, 32'h00001000, dbs_pkg::SIZE_LONG, 1'b0);
    one(dbs_pkg::ACK_PORT8, 32'h00001002, dbs_pkg::SIZE_WORD, 1'b0);
    one(dbs_pkg::ACK_PORT16, 32'h00001001, dbs_pkg::SIZE_LONG, 1'b0);
    one(dbs_pkg::ACK_PORT16, 32'h00001003, dbs_pkg::SIZE_WORD, 1'b0);
    one(dbs_pkg::ACK_PORT32, 32'h00001FFF, dbs_pkg::SIZE_LONG, 1'b0);
    one(dbs_pkg::ACK_PORT32, 32'h00002005, dbs_pkg::SIZE_LONG, 1'b1);
    for (int i = 0; i < 4; i++) one(dbs_pkg::ACK_PORT32, 32'h10 + i, dbs_pkg::SIZE_BYTE, 1'b0);
    // slow port stalls the sizer so the fifo fills and refuses
    pw <= dbs_pkg::ACK_PORT8;
    waits <= 4'h9;
    @(posedge REF_CLK);
    for (int i = 0; i < 19; i++) send(32'h4000 + 4 * i, dbs_pkg::SIZE_LONG, 1'b1, 1'b0);
    drain();
    chk(saw_full, 1);
    // random mix of sizes, offsets, ports, waits and enable gaps
    rnd_en <= 1'b1;
    repeat (30)
    begin
      pw <= 2'($urandom % 3 + 1);
      waits <= 4'($urandom % 4);
      @(posedge REF_CLK);
      repeat (6) send($urandom, 2'($urandom), 1'($urandom), $urandom % 6 == 0);
      drain();
    end
    chk(q.size(), 0);
    test_done();
  end
endmodule // dynamic_bus_sizing_write_mux_tb
